/* File: hdl/omsel_pkg.sv */
package omsel_pkg;
	localparam int FREQ_W = 16;

	// Register map of the classic Wishbone slave (byte offsets, compared directly with ADR_I).
	localparam logic [7:0] ADDR_SETTING = 8'h00;
	localparam logic [7:0] ADDR_REQUEST = 8'h04;
	localparam logic [7:0] ADDR_STATUS  = 8'h08;
	localparam logic [7:0] ADDR_FREQ    = 8'h0c;
	localparam logic [7:0] ADDR_PWRITE  = 8'h10;

	// Operation source setting values.
	localparam logic [2:0] SET_EXT_SWITCH   = 3'h0;
	localparam logic [2:0] SET_KEYPAD_FIXED = 3'h1;
	localparam logic [2:0] SET_EXT_FIXED    = 3'h2;
	localparam logic [2:0] SET_COMB1        = 3'h3;
	localparam logic [2:0] SET_COMB2        = 3'h4;
	localparam logic [2:0] SET_SWITCHOVER   = 3'h6;
	localparam logic [2:0] SET_RESET_VAL    = 3'h0;

	// Output terminal function codes for the keypad mode status.
	localparam logic [7:0] FUNC_KEYPAD_POS = 8'h0a;
	localparam logic [7:0] FUNC_KEYPAD_NEG = 8'h6e;

	// Request field positions in the request register.
	localparam int REQ_KEYPAD_BIT = 0;
	localparam int REQ_EXT_BIT    = 1;
	localparam int REQ_NET_BIT    = 2;
	localparam int REQ_SRC_BIT    = 3;

	// Status bit positions.
	localparam int ST_REFUSED_BIT = 8;
	localparam int ST_PWREF_BIT   = 9;

	typedef enum logic [1:0] {
		OMSEL_EXT    = 2'b00,
		OMSEL_KEYPAD = 2'b01,
		OMSEL_NET    = 2'b11,
		OMSEL_COMB   = 2'b10
	} omsel_mode_t;

	typedef struct packed {
		logic              fwd;
		logic              rev;
		logic [FREQ_W-1:0] freq;
	} omsel_cmd_t;

	typedef struct packed {
		omsel_mode_t       mode;
		logic              init_done;
		logic [2:0]        setting;
		logic [7:0]        out_func;
		logic              held_fwd;
		logic              held_rev;
		logic [FREQ_W-1:0] held_freq;
		logic              refused;
		logic              pw_refused;
		logic [31:0]       pwrite_data;
		logic              pwrite_stb;
		omsel_cmd_t        cmd;
		logic              keypad_term;
		logic              stop;
		logic              ack;
		logic [31:0]       rdata;
	} omsel_state_t;
endpackage : omsel_pkg

/* File: hdl/omsel_top.sv */
`timescale 1ns/1ps
module omsel_top #(
	parameter int FREQ_W = omsel_pkg::FREQ_W
) (
	// Clock and reset.
	input  wire logic              CORE_CLK,
	input  wire logic              RESET_N,
	// Classic Wishbone slave.
	input  wire logic              CYC_I,
	input  wire logic              STB_I,
	input  wire logic              WE_I,
	input  wire logic [7:0]        ADR_I,
	input  wire logic [3:0]        SEL_I,
	input  wire logic [31:0]       DAT_I,
	output logic      [31:0]       DAT_O,
	output logic                   ACK_O,
	// External terminals.
	input  wire logic              FORWARD_RUN_INPUT,
	input  wire logic              REVERSE_RUN_INPUT,
	input  wire logic              CURRENT_INPUT_SELECT,
	input  wire logic              MULTI_SPEED_ACTIVE,
	input  wire logic              JOG_ACTIVE,
	input  wire logic [FREQ_W-1:0] ANALOG1_FREQ,
	input  wire logic [FREQ_W-1:0] ANALOG2_FREQ,
	input  wire logic [FREQ_W-1:0] MULTI_SPEED_FREQ,
	input  wire logic [FREQ_W-1:0] JOG_FREQ,
	// Keypad panel.
	input  wire logic              KEY_TOGGLE,
	input  wire logic              KEY_EXTERNAL,
	input  wire logic              KEY_FWD,
	input  wire logic              KEY_REV,
	input  wire logic              KEY_RESET_STOP,
	input  wire logic [FREQ_W-1:0] KEYPAD_FREQ,
	// Network link commands.
	input  wire logic              NET_FWD,
	input  wire logic              NET_REV,
	input  wire logic [FREQ_W-1:0] NET_FREQ,
	// Drive outputs.
	output logic                   RUN_FWD,
	output logic                   RUN_REV,
	output logic      [FREQ_W-1:0] FREQ_CMD,
	output logic                   STOP_REQ,
	output logic                   KEYPAD_MODE_TERM,
	output logic      [1:0]        MODE,
	output logic      [31:0]       PARAM_WRITE_DATA,
	output logic                   PARAM_WRITE_STB
);
	initial begin
		if (FREQ_W < 1 || FREQ_W > 32) begin
			$error("FREQ_W must lie between 1 and 32");
		end
	end

	// Terminal and panel inputs are asynchronous to the core clock.
	localparam int NSYNC = 10;
	logic [NSYNC-1:0] sync1;
	logic [NSYNC-1:0] sync2;
	logic [NSYNC-1:0] raw_in;
	assign raw_in = {FORWARD_RUN_INPUT, REVERSE_RUN_INPUT, CURRENT_INPUT_SELECT,
		MULTI_SPEED_ACTIVE, JOG_ACTIVE, KEY_TOGGLE, KEY_EXTERNAL, KEY_FWD, KEY_REV,
		KEY_RESET_STOP};

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
		end
	end

	logic s_fwd, s_rev, s_cis, s_ms, s_jog, s_tog, s_ext, s_kf, s_kr, s_stop;
	assign {s_fwd, s_rev, s_cis, s_ms, s_jog, s_tog, s_ext, s_kf, s_kr, s_stop} = sync2;

	// The toggle and external panel keys act on their rising edge only.
	logic tog_d, ext_d;
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			tog_d <= 1'b0;
			ext_d <= 1'b0;
		end else begin
			tog_d <= s_tog;
			ext_d <= s_ext;
		end
	end

	// Frequency selection in external mode; multi-speed wins over jog and analog.
	function automatic logic [FREQ_W-1:0] ext_freq(input logic ms, input logic jog,
		input logic cis, input logic [FREQ_W-1:0] ms_f, input logic [FREQ_W-1:0] jog_f,
		input logic [FREQ_W-1:0] a1, input logic [FREQ_W-1:0] a2);
		if (ms) begin
			return ms_f;
		end else if (jog) begin
			return jog_f;
		end else if (cis) begin
			return a2;
		end
		return a1;
	endfunction : ext_freq

	function automatic logic fixed_setting(input logic [2:0] s);
		return s == omsel_pkg::SET_KEYPAD_FIXED || s == omsel_pkg::SET_COMB1 ||
			s == omsel_pkg::SET_COMB2;
	endfunction : fixed_setting

	typedef struct packed {
		omsel_pkg::omsel_mode_t       mode;
		logic                         init_done;
		logic [2:0]                   setting;
		logic [7:0]                   out_func;
		logic                         held_fwd;
		logic                         held_rev;
		logic [FREQ_W-1:0]            held_freq;
		logic                         refused;
		logic                         pw_refused;
		logic [31:0]                  pwrite_data;
		logic                         pwrite_stb;
		logic                         fwd;
		logic                         rev;
		logic [FREQ_W-1:0]            freq;
		logic                         keypad_term;
		logic                         stop;
		logic                         ack;
		logic [31:0]                  rdata;
		logic [FREQ_W-1:0]            kpf_last;
		logic [FREQ_W-1:0]            nfq_last;
	} omsel_st_t;

	omsel_st_t st;
	omsel_st_t next_st;

	logic              bus_req;
	logic              wr;
	logic [FREQ_W-1:0] efreq;
	assign bus_req = CYC_I && STB_I && !st.ack;
	assign wr      = bus_req && WE_I && SEL_I[0];
	assign efreq   = ext_freq(s_ms, s_jog, s_cis, MULTI_SPEED_FREQ, JOG_FREQ,
		ANALOG1_FREQ, ANALOG2_FREQ);

	always_comb begin
		logic                        req_key;
		logic                        req_ext;
		logic                        req_net;
		logic                        net_src;
		omsel_pkg::omsel_mode_t      target;
		logic                        want;
		logic                        allowed;
		logic                        refuse_evt;
		req_key    = 1'b0;
		req_ext    = 1'b0;
		req_net    = 1'b0;
		net_src    = 1'b0;
		target     = st.mode;
		want       = 1'b0;
		allowed    = 1'b0;
		refuse_evt = 1'b0;
		next_st = st;
		next_st.pwrite_stb = 1'b0;
		next_st.ack        = bus_req;
		next_st.rdata      = '0;
		next_st.kpf_last   = KEYPAD_FREQ;
		next_st.nfq_last   = NET_FREQ;

		// Power-on entry mode from the setting.
		if (!st.init_done) begin
			next_st.init_done = 1'b1;
			next_st.held_freq = KEYPAD_FREQ;
			case (st.setting)
				omsel_pkg::SET_KEYPAD_FIXED: next_st.mode = omsel_pkg::OMSEL_KEYPAD;
				omsel_pkg::SET_COMB1,
				omsel_pkg::SET_COMB2:    next_st.mode = omsel_pkg::OMSEL_COMB;
				default:                 next_st.mode = omsel_pkg::OMSEL_EXT;
			endcase
		end

		// Mode requests come from panel keys or the link register.
		if (wr && ADR_I == omsel_pkg::ADDR_REQUEST) begin
			req_key = DAT_I[omsel_pkg::REQ_KEYPAD_BIT];
			req_ext = DAT_I[omsel_pkg::REQ_EXT_BIT];
			req_net = DAT_I[omsel_pkg::REQ_NET_BIT];
			net_src = DAT_I[omsel_pkg::REQ_SRC_BIT];
		end
		if (s_tog && !tog_d) begin
			req_key = st.mode != omsel_pkg::OMSEL_KEYPAD;
			req_ext = st.mode == omsel_pkg::OMSEL_KEYPAD;
		end
		if (s_ext && !ext_d) begin
			req_ext = 1'b1;
		end
		if (req_key) begin
			target = omsel_pkg::OMSEL_KEYPAD;
			want   = 1'b1;
		end else if (req_ext) begin
			target = omsel_pkg::OMSEL_EXT;
			want   = 1'b1;
		end else if (req_net && net_src) begin
			target = omsel_pkg::OMSEL_NET;
			want   = 1'b1;
		end

		case (st.setting)
			omsel_pkg::SET_EXT_SWITCH: allowed = !(st.fwd || st.rev) || st.stop;
			omsel_pkg::SET_EXT_FIXED:  allowed = target != omsel_pkg::OMSEL_KEYPAD;
			omsel_pkg::SET_SWITCHOVER: allowed = 1'b1;
			default:                   allowed = !fixed_setting(st.setting);
		endcase

		if (want && st.init_done) begin
			if (allowed && target != st.mode) begin
				next_st.mode = target;
				if (target != omsel_pkg::OMSEL_EXT) begin
					next_st.held_fwd  = st.fwd;
					next_st.held_rev  = st.rev;
					next_st.held_freq = st.freq;
				end
			end else if (!allowed) begin
				refuse_evt      = 1'b1;
				next_st.refused = 1'b1;
			end
		end

		// Command routing by mode.
		case (st.mode)
			omsel_pkg::OMSEL_EXT: begin
				next_st.fwd  = s_fwd;
				next_st.rev  = s_rev;
				next_st.freq = efreq;
			end
			omsel_pkg::OMSEL_COMB: begin
				if (st.setting == omsel_pkg::SET_COMB1) begin
					next_st.fwd  = s_fwd;
					next_st.rev  = s_rev;
					next_st.freq = s_ms ? MULTI_SPEED_FREQ :
						(s_cis ? ANALOG2_FREQ : KEYPAD_FREQ);
				end else begin
					next_st.fwd  = s_kf;
					next_st.rev  = s_kr;
					next_st.freq = efreq;
				end
			end
			omsel_pkg::OMSEL_KEYPAD: begin
				next_st.fwd  = s_kf || st.held_fwd;
				next_st.rev  = s_kr || st.held_rev;
				next_st.freq = st.held_freq;
				if (s_kf || s_kr) begin
					next_st.held_fwd = s_kf;
					next_st.held_rev = s_kr;
				end
			end
			omsel_pkg::OMSEL_NET: begin
				next_st.fwd  = NET_FWD || st.held_fwd;
				next_st.rev  = NET_REV || st.held_rev;
				next_st.freq = st.held_freq;
			end
			default: begin
				next_st.fwd  = 1'b0;
				next_st.rev  = 1'b0;
			end
		endcase
		// Only a fresh dial or link entry replaces the carried frequency, so a switch-over to keypad or network
		// keeps the speed that was in use until the new source really gives a new one.
		if (st.mode == omsel_pkg::OMSEL_KEYPAD && KEYPAD_FREQ != st.kpf_last) begin
			next_st.held_freq = KEYPAD_FREQ;
		end
		if (st.mode == omsel_pkg::OMSEL_NET && NET_FREQ != st.nfq_last) begin
			next_st.held_freq = NET_FREQ;
		end

		// The reset key stops the drive in every mode.
		next_st.stop = s_stop;
		if (s_stop) begin
			next_st.fwd      = 1'b0;
			next_st.rev      = 1'b0;
			next_st.held_fwd = 1'b0;
			next_st.held_rev = 1'b0;
		end

		next_st.keypad_term = (st.mode == omsel_pkg::OMSEL_KEYPAD) ^
			(st.out_func == omsel_pkg::FUNC_KEYPAD_NEG);

		// Register writes.
		if (wr) begin
			case (ADR_I)
				omsel_pkg::ADDR_SETTING: begin
					if (DAT_I[2:0] != 3'h5 && DAT_I[2:0] != 3'h7) begin
						next_st.setting = DAT_I[2:0];
					end
					next_st.out_func = DAT_I[15:8];
					// A new setting reruns the power-on entry, since reset clears it.
					next_st.init_done = 1'b0;
				end
				omsel_pkg::ADDR_STATUS: begin
					if (DAT_I[omsel_pkg::ST_REFUSED_BIT]) begin
						next_st.refused = refuse_evt;
					end
					if (DAT_I[omsel_pkg::ST_PWREF_BIT]) begin
						next_st.pw_refused = 1'b0;
					end
				end
				omsel_pkg::ADDR_PWRITE: begin
					if (st.mode == omsel_pkg::OMSEL_EXT && !DAT_I[31]) begin
						next_st.pw_refused = 1'b1;
					end else begin
						next_st.pwrite_data = DAT_I;
						next_st.pwrite_stb  = 1'b1;
					end
				end
				default: ;
			endcase
		end

		if (bus_req && !WE_I) begin
			case (ADR_I)
				omsel_pkg::ADDR_SETTING: next_st.rdata = {16'h0, st.out_func, 5'h0, st.setting};
				omsel_pkg::ADDR_STATUS:  next_st.rdata = {22'h0, st.pw_refused, st.refused,
					4'h0, st.rev, st.fwd, st.mode};
				omsel_pkg::ADDR_FREQ:    next_st.rdata = 32'(st.freq);
				default:                 next_st.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st          <= '0;
			st.mode     <= omsel_pkg::OMSEL_EXT;
			st.setting  <= omsel_pkg::SET_RESET_VAL;
			st.out_func <= omsel_pkg::FUNC_KEYPAD_POS;
		end else begin
			st <= next_st;
		end
	end

	assign DAT_O            = st.rdata;
	assign ACK_O            = st.ack;
	assign RUN_FWD          = st.fwd;
	assign RUN_REV          = st.rev;
	assign FREQ_CMD         = st.freq;
	assign STOP_REQ         = st.stop;
	assign KEYPAD_MODE_TERM = st.keypad_term;
	assign MODE             = st.mode;
	assign PARAM_WRITE_DATA = st.pwrite_data;
	assign PARAM_WRITE_STB  = st.pwrite_stb;

	AST_FIXED_KEYPAD: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		st.init_done && st.setting == omsel_pkg::SET_KEYPAD_FIXED &&
		$past(st.setting) == omsel_pkg::SET_KEYPAD_FIXED && $past(st.init_done)
		|-> $stable(st.mode)) else $error("mode changed under fixed keypad setting");
	AST_EXT_FIXED: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		$past(st.setting) == omsel_pkg::SET_EXT_FIXED && $past(st.mode) == omsel_pkg::OMSEL_EXT
		&& $past(st.init_done) |-> st.mode != omsel_pkg::OMSEL_KEYPAD)
		else $error("keypad entered under fixed external setting");
	AST_EXT_ROUTE: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		st.mode == omsel_pkg::OMSEL_EXT && !s_stop |=> st.fwd == $past(s_fwd))
		else $error("external run not routed");
	AST_STOP: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		s_stop |=> !st.fwd && !st.rev && st.stop) else $error("reset key did not stop");
	AST_KEYPAD_TERM: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		st.mode == omsel_pkg::OMSEL_KEYPAD && st.out_func == omsel_pkg::FUNC_KEYPAD_POS
		&& $stable(st.mode) |=> st.keypad_term) else $error("keypad terminal not driven");
	AST_PWRITE: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		wr && ADR_I == omsel_pkg::ADDR_PWRITE && st.mode == omsel_pkg::OMSEL_EXT && !DAT_I[31]
		|=> !st.pwrite_stb && st.pw_refused) else $error("parameter write not refused");
	AST_HOLD: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		$past(st.init_done) && $past(st.mode) == omsel_pkg::OMSEL_EXT &&
		st.mode == omsel_pkg::OMSEL_KEYPAD |-> st.held_freq == $past(st.freq))
		else $error("frequency not held");
	AST_ACK: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O) else $error("bus ack timing");
	COV_TO_KEYPAD: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
		$past(st.mode) == omsel_pkg::OMSEL_EXT && st.mode == omsel_pkg::OMSEL_KEYPAD);
	COV_TO_NET: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
		st.mode == omsel_pkg::OMSEL_NET);
	COV_REFUSED: cover property (@(posedge CORE_CLK) disable iff (!RESET_N) st.refused);
endmodule : omsel_top

/* File: tb/omsel_partner.sv */
`timescale 1ns/1ps
module omsel_partner (
	// Bus clock and slave answer.
	input  wire logic        clk,
	input  wire logic        ack,
	input  wire logic [31:0] dat_in,
	// Bus request.
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic      [7:0]  adr,
	output logic      [3:0]  sel,
	output logic      [31:0] dat_out
);
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat_out = 32'h00000000;
	end

	// Enter just after a rising edge; the request holds until ack is sampled.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		dat_out <= d;
		@(posedge clk);
		// Only the bench's own cycle ceiling ends a wait on a silent slave.
		while (ack !== 1'b1) begin
			@(posedge clk);
		end
		q = dat_in;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : xfer

	// The panel leaves the source bit clear, the link master sets it.
	task automatic mode_req(input logic from_net, input logic [2:0] target);
		logic [31:0] q;
		xfer(1'b1, omsel_pkg::ADDR_REQUEST, {28'h0000000, from_net, target}, q);
	endtask : mode_req
endmodule : omsel_partner

/* File: tb/omsel_top_tb.sv */
`timescale 1ns/1ps
module omsel_top_tb;
	typedef struct packed {
		logic f, r, m, j, ef, er;
		logic [15:0] eq;
	} omsel_row_t;
	localparam omsel_row_t rows [4] = '{{6'h22, 16'h1111}, {6'h19, 16'h3333},
		{6'h26, 16'h4444}, {6'h00, 16'h1111}};
	localparam logic [1:0] EXT = 2'b00;
	localparam logic [1:0] KPD = 2'b01;
	localparam logic [1:0] NETM = 2'b11;
	localparam logic [1:0] CMB = 2'b10;
	logic        clk, rst_n, cyc, stb, we, ack, fi, ri, cis, ms, jog;
	logic        kt, ke, kf, kr, ks, nf, nr, rf, rr, stop, term, pws;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] di, dq, pwd, q, pw_last;
	logic [15:0] a1, a2, msf, jgf, kpf, nfq, freq;
	logic [1:0]  mode;
	int          err_count, checked, pw_cnt, cycles;

	omsel_top dut_u (.CORE_CLK(clk), .RESET_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.ADR_I(adr), .SEL_I(sel), .DAT_I(di), .DAT_O(dq), .ACK_O(ack),
		.FORWARD_RUN_INPUT(fi), .REVERSE_RUN_INPUT(ri), .CURRENT_INPUT_SELECT(cis),
		.MULTI_SPEED_ACTIVE(ms), .JOG_ACTIVE(jog), .ANALOG1_FREQ(a1), .ANALOG2_FREQ(a2),
		.MULTI_SPEED_FREQ(msf), .JOG_FREQ(jgf), .KEY_TOGGLE(kt), .KEY_EXTERNAL(ke),
		.KEY_FWD(kf), .KEY_REV(kr), .KEY_RESET_STOP(ks), .KEYPAD_FREQ(kpf), .NET_FWD(nf),
		.NET_REV(nr), .NET_FREQ(nfq), .RUN_FWD(rf), .RUN_REV(rr), .FREQ_CMD(freq),
		.STOP_REQ(stop), .KEYPAD_MODE_TERM(term), .MODE(mode), .PARAM_WRITE_DATA(pwd),
		.PARAM_WRITE_STB(pws));
	omsel_partner part_u (.clk(clk), .ack(ack), .dat_in(dq), .cyc(cyc), .stb(stb),
		.we(we), .adr(adr), .sel(sel), .dat_out(di));

	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (pws === 1'b1) begin
			pw_cnt++;
			pw_last = pwd;
		end
		if (cycles == 20000) begin
			err_count++;
			conclude();
		end
	end

	task automatic conclude();
		if (err_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		part_u.xfer(1'b1, a, d, q);
	endtask : wr

	task automatic cfg(input logic [2:0] s, input logic [7:0] f);
		wr(omsel_pkg::ADDR_SETTING, {16'h0000, f, 5'h00, s});
	endtask : cfg

	// Reset clears the setting, so each scenario resets and then writes its setting,
	// which reruns the power-on mode entry.
	task automatic reboot(input logic [2:0] s);
		rst_n <= 1'b0;
		tick(3);
		rst_n <= 1'b1;
		tick(3);
		cfg(s, 8'h0a);
	endtask : reboot

	task automatic want_mode(input logic [1:0] m, input string what);
		part_u.xfer(1'b0, omsel_pkg::ADDR_STATUS, 32'h0, q);
		chk({30'h0, q[1:0]}, {30'h0, m}, what);
		chk({30'h0, mode}, {30'h0, m}, what);
	endtask : want_mode

	task automatic want_out(input logic f, input logic r, input logic [15:0] e, input string w);
		tick(5);
		chk({14'h0, rf, rr, freq}, {14'h0, f, r, e}, w);
	endtask : want_out

	task automatic press(input logic ext);
		if (ext) ke <= 1'b1;
		else kt <= 1'b1;
		tick(4);
		ke <= 1'b0;
		kt <= 1'b0;
		tick(5);
	endtask : press

	initial begin
		{clk, rst_n, fi, ri, cis, ms, jog, kt, ke, kf, kr, ks, nf, nr} = '0;
		{a1, a2, msf, jgf, kpf, nfq} = 96'h111122223333444455556666;
		{err_count, checked, pw_cnt, cycles} = '0;
		tick(12);
		rst_n <= 1'b1;
		tick(3);
		part_u.xfer(1'b0, omsel_pkg::ADDR_SETTING, 32'h0, q);
		chk(q, 32'h00000a00, "setting reset");
		want_mode(EXT, "power-on");
		part_u.xfer(1'b0, 8'h20, 32'h0, q);
		chk(q, 32'h0, "unmapped");
		chk({31'h0, term}, 32'h0, "term ext");
		foreach (rows[i]) begin
			{fi, ri, ms, jog} <= {rows[i].f, rows[i].r, rows[i].m, rows[i].j};
			want_out(rows[i].ef, rows[i].er, rows[i].eq, "ext row");
		end
		wr(omsel_pkg::ADDR_PWRITE, 32'h00000012);
		part_u.xfer(1'b0, omsel_pkg::ADDR_STATUS, 32'h0, q);
		chk({31'h0, q[9]}, 32'h1, "pw refused");
		wr(omsel_pkg::ADDR_PWRITE, 32'h80000034);
		tick(2);
		chk(pw_cnt, 1, "designated");
		chk(pw_last, 32'h80000034, "pw data");
		wr(omsel_pkg::ADDR_STATUS, 32'h00000300);
		press(1'b0);
		want_mode(KPD, "toggle key");
		chk({31'h0, term}, 32'h1, "term kpd");
		wr(omsel_pkg::ADDR_PWRITE, 32'h00000056);
		tick(2);
		chk(pw_cnt, 2, "pw keypad");
		press(1'b1);
		want_mode(EXT, "ext key");
		cfg(3'h0, 8'h6e);
		tick(2);
		chk({31'h0, term}, 32'h1, "term inv ext");
		press(1'b0);
		chk({31'h0, term}, 32'h0, "term inv kpd");
		press(1'b1);
		reboot(3'h2);
		want_mode(EXT, "fixed ext");
		part_u.mode_req(1'b0, 3'b001);
		press(1'b0);
		want_mode(EXT, "ext locked");
		chk({31'h0, q[8]}, 32'h1, "refused flag");
		reboot(3'h1);
		want_mode(KPD, "fixed kpd");
		kf <= 1'b1;
		want_out(1'b1, 1'b0, 16'h5555, "kpd run");
		part_u.mode_req(1'b0, 3'b010);
		part_u.mode_req(1'b1, 3'b100);
		want_mode(KPD, "kpd locked");
		kf <= 1'b0;
		reboot(3'h3);
		want_mode(CMB, "comb1");
		fi <= 1'b1;
		want_out(1'b1, 1'b0, 16'h5555, "comb1 run");
		ms <= 1'b1;
		want_out(1'b1, 1'b0, 16'h3333, "comb1 ms");
		{ms, cis} <= 2'b01;
		want_out(1'b1, 1'b0, 16'h2222, "comb1 au");
		{cis, fi} <= 2'b00;
		part_u.mode_req(1'b0, 3'b001);
		want_mode(CMB, "comb1 locked");
		reboot(3'h4);
		{ri, kf} <= 2'b11;
		want_out(1'b1, 1'b0, 16'h1111, "comb2 run");
		jog <= 1'b1;
		want_out(1'b1, 1'b0, 16'h4444, "comb2 jog");
		{jog, ri, kf} <= 3'b000;
		part_u.mode_req(1'b0, 3'b010);
		want_mode(CMB, "comb2 locked");
		reboot(3'h6);
		fi <= 1'b1;
		want_out(1'b1, 1'b0, 16'h1111, "sw ext");
		press(1'b0);
		chk({31'h0, stop}, 32'h0, "no stop");
		want_out(1'b1, 1'b0, 16'h1111, "ext to kpd");
		part_u.mode_req(1'b0, 3'b100);
		want_mode(KPD, "panel net");
		part_u.mode_req(1'b1, 3'b100);
		want_mode(NETM, "kpd to net");
		want_out(1'b1, 1'b0, 16'h1111, "net keeps");
		part_u.mode_req(1'b0, 3'b001);
		want_out(1'b1, 1'b0, 16'h1111, "net to kpd");
		{fi, ri, a1} <= {2'b01, 16'h7777};
		press(1'b1);
		want_out(1'b0, 1'b1, 16'h7777, "kpd to ext");
		part_u.mode_req(1'b1, 3'b100);
		want_out(1'b0, 1'b1, 16'h7777, "ext to net");
		{fi, ri, a1} <= {2'b10, 16'h1111};
		part_u.mode_req(1'b1, 3'b010);
		want_mode(EXT, "net to ext");
		want_out(1'b1, 1'b0, 16'h1111, "net ext");
		part_u.xfer(1'b0, omsel_pkg::ADDR_FREQ, 32'h0, q);
		chk(q, 32'h00001111, "freq reg");
		part_u.xfer(1'b0, omsel_pkg::ADDR_STATUS, 32'h0, q);
		chk({30'h0, q[3:2]}, 32'h1, "status run");
		ks <= 1'b1;
		tick(5);
		chk({31'h0, stop}, 32'h1, "stop key");
		ks <= 1'b0;
		tick(5);
		chk({31'h0, stop}, 32'h0, "stop off");
		conclude();
	end
endmodule : omsel_top_tb
